/* File: hdl/vb_map.svh */
// address map, codes and timing constants of the vme bridge
`ifndef VB_MAP_SVH
`define VB_MAP_SVH
`define VB_WIN_NUM 12
`define VB_WIN_LSB 23
`define VB_WIN_MSB 26
`define VB_TAG_LSB 27
`define VB_PIO_TAG 13'h0002
`define VB_SLV_LSB 24
`define VB_AM_SD_SGL 6'h0d
`define VB_AM_UD_SGL 6'h09
`define VB_AM_SD_BLT 6'h0f
`define VB_AM_UD_BLT 6'h0b
`define VB_AM_SD_D64 6'h0c
`define VB_AM_UD_D64 6'h08
`define VB_D32_STEP 32'h0000_0004
`define VB_D64_STEP 32'h0000_0008
`define VB_MEM_STEP 40'h00_0000_0008
`define VB_CLK_NS 100
`define VB_DTACK_TO_NS 10000
`define VB_DTACK_TO_CYC (`VB_DTACK_TO_NS / `VB_CLK_NS)
`define VB_FIFO_W 64
`define VB_FIFO_DEPTH 16
`endif

/* File: hdl/vb_pkg.sv */
// state types of the vme bridge
package vb_pkg;
    typedef enum logic [1:0] {
        M_IDLE = 2'b00, M_BUSREQ = 2'b01, M_STROBE = 2'b10, M_RELEASE = 2'b11
    } vb_mst_st_t;
    typedef enum logic [1:0] {
        SL_IDLE = 2'b00, SL_WAIT = 2'b01, SL_ACK = 2'b10
    } vb_slv_st_t;
    typedef enum logic [1:0] {
        OWN_NONE = 2'b00, OWN_SLV = 2'b01, OWN_FIFO = 2'b10, OWN_FETCH = 2'b11
    } vb_own_t;
endpackage

/* File: hdl/vb_fifo.sv */
// flip-flop fifo with valid/ready on both sides, depth a power of two
`timescale 1ns/100ps
module vb_fifo #(
    parameter int W = 64,
    parameter int D = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;

    // extra pointer bit tells full from empty
    assign o_valid = (wr_q != rd_q);
    assign o_ready = (wr_q != {~rd_q[AW], rd_q[AW-1:0]});
    assign o_data = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (i_valid && o_ready) begin
                wr_q <= wr_q + 1'b1;
            end
            if (o_valid && i_ready) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            mem_q[wr_q[AW-1:0]] <= i_data;
        end
    end
endmodule

/* File: hdl/vb_bridge.sv */
// vme bridge: pio master, slave into host memory and dma engine
`timescale 1ns/100ps
`include "vb_map.svh"
module vb_bridge (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // cpu side of the system bus
    input wire logic i_sb_req,
    input wire logic i_sb_we,
    input wire logic [39:0] i_sb_addr,
    input wire logic [63:0] i_sb_wdata,
    output logic o_sb_ready,
    output logic o_sb_rsp_valid,
    output logic o_sb_rsp_err,
    output logic [63:0] o_sb_rsp_data,
    // window setup and master privilege
    input wire logic i_win_we,
    input wire logic [3:0] i_win_idx,
    input wire logic [8:0] i_win_base,
    input wire logic i_am_super,
    // memory side of the system bus
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [39:0] o_mem_addr,
    output logic [63:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [63:0] i_mem_rdata,
    // vme master
    output logic o_vme_br,
    input wire logic i_vme_bg,
    output logic o_vme_as,
    output logic o_vme_ds,
    output logic o_vme_write,
    output logic [5:0] o_vme_am,
    output logic o_vme_d64,
    output logic [31:0] o_vme_addr,
    output logic [63:0] o_vme_wdata,
    input wire logic i_vme_dtack,
    input wire logic i_vme_berr,
    input wire logic [63:0] i_vme_rdata,
    // vme slave
    input wire logic i_vs_as,
    input wire logic i_vs_ds,
    input wire logic i_vs_write,
    input wire logic [31:0] i_vs_addr,
    input wire logic [63:0] i_vs_wdata,
    input wire logic [7:0] i_slv_vbase,
    input wire logic [15:0] i_slv_hbase,
    output logic o_vs_dtack,
    output logic [63:0] o_vs_rdata,
    // dma engine
    input wire logic i_dma_start,
    input wire logic i_dma_rd,
    input wire logic i_dma_d64,
    input wire logic [39:0] i_dma_haddr,
    input wire logic [31:0] i_dma_vaddr,
    input wire logic [15:0] i_dma_len,
    output logic o_dma_busy,
    output logic o_dma_done,
    output logic o_dma_err
);
    vb_pkg::vb_mst_st_t mst_q;
    vb_pkg::vb_slv_st_t slv_q;
    vb_pkg::vb_own_t own_q;
    logic [8:0] win_q [`VB_WIN_NUM];
    logic pio_q, wr_q, rsp_v_q, rsp_err_q;
    logic [31:0] vaddr_q, dvaddr_q, gath_q;
    logic [63:0] vwdata_q, rsp_data_q, mem_wdata_q, vs_rdata_q, wbuf_q;
    logic [7:0] to_q;
    logic dma_busy_q, dma_done_q, dma_err_q, dma_rd_q, dma_d64_q, half_q;
    logic wbuf_v_q, mem_we_q;
    logic [39:0] haddr_q, mem_addr_q;
    logic [16:0] beats_q;
    logic [15:0] fetch_q;
    logic pio_take, dma_go, beat_ok, beat_err, to_hit, dma_fin, slv_hit;
    logic fifo_in_rdy, fifo_push, fifo_out_v, fifo_pop;
    logic [63:0] fifo_in_d, fifo_out_d;

    function automatic logic pio_hit(input logic [39:0] a);
        return (a[39:`VB_TAG_LSB] == `VB_PIO_TAG) &&
            (a[`VB_WIN_MSB:`VB_WIN_LSB] < 4'(`VB_WIN_NUM));
    endfunction

    function automatic logic [5:0] am_code(input logic sup, blk, d64);
        if (d64) begin
            return sup ? `VB_AM_SD_D64 : `VB_AM_UD_D64;
        end
        if (blk) begin
            return sup ? `VB_AM_SD_BLT : `VB_AM_UD_BLT;
        end
        return sup ? `VB_AM_SD_SGL : `VB_AM_UD_SGL;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode and handshake terms
    assign to_hit = (to_q == 8'(`VB_DTACK_TO_CYC));
    assign beat_ok = (mst_q == vb_pkg::M_STROBE) && i_vme_dtack;
    assign beat_err = (mst_q == vb_pkg::M_STROBE) && !i_vme_dtack &&
        (i_vme_berr || to_hit);
    assign pio_take = i_sb_req && o_sb_ready && pio_hit(i_sb_addr);
    // a read beat waits for fifo room so the gathered word is never dropped
    assign dma_go = dma_busy_q && !dma_err_q && (beats_q != 17'h0) &&
        (dma_rd_q ? fifo_in_rdy : wbuf_v_q);
    assign fifo_push = beat_ok && !pio_q && dma_rd_q &&
        (dma_d64_q || half_q);
    assign fifo_in_d = dma_d64_q ? i_vme_rdata :
        {i_vme_rdata[31:0], gath_q};
    assign fifo_pop = (own_q == vb_pkg::OWN_FIFO) && i_mem_ack;
    assign dma_fin = dma_busy_q && (beats_q == 17'h0) &&
        (mst_q == vb_pkg::M_IDLE) &&
        (!dma_rd_q || (!fifo_out_v && own_q != vb_pkg::OWN_FIFO));
    // own master cycles are never answered by the slave side
    assign slv_hit = i_vs_as && i_vs_ds && !o_vme_as &&
        (i_vs_addr[31:`VB_SLV_LSB] == i_slv_vbase);

    ////////////////////////////////////////////////////////////////////////
    // window bases
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < `VB_WIN_NUM; i++) begin
                win_q[i] <= 9'h000;
            end
        end else if (i_win_we && i_win_idx < 4'(`VB_WIN_NUM)) begin
            win_q[i_win_idx] <= i_win_base;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vme master cycle, shared by pio and dma with pio first
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mst_q <= vb_pkg::M_IDLE;
            pio_q <= 1'b0;
            wr_q <= 1'b0;
            vaddr_q <= 32'h0;
            vwdata_q <= 64'h0;
            to_q <= 8'h00;
        end else begin
            unique case (mst_q)
                vb_pkg::M_IDLE: begin
                    if (pio_take) begin
                        pio_q <= 1'b1;
                        wr_q <= i_sb_we;
                        vaddr_q <= {win_q[i_sb_addr[`VB_WIN_MSB:`VB_WIN_LSB]],
                            i_sb_addr[`VB_WIN_LSB-1:0]};
                        vwdata_q <= i_sb_wdata;
                        mst_q <= vb_pkg::M_BUSREQ;
                    end else if (dma_go) begin
                        pio_q <= 1'b0;
                        wr_q <= !dma_rd_q;
                        vaddr_q <= dvaddr_q;
                        vwdata_q <= (dma_d64_q || !half_q) ? wbuf_q :
                            {32'h0, wbuf_q[63:32]};
                        mst_q <= vb_pkg::M_BUSREQ;
                    end
                end
                vb_pkg::M_BUSREQ: begin
                    if (i_vme_bg) begin
                        to_q <= 8'h00;
                        mst_q <= vb_pkg::M_STROBE;
                    end
                end
                vb_pkg::M_STROBE: begin
                    to_q <= to_q + 8'h01;
                    if (i_vme_dtack || i_vme_berr || to_hit) begin
                        mst_q <= vb_pkg::M_RELEASE;
                    end
                end
                vb_pkg::M_RELEASE: begin
                    if (!i_vme_dtack) begin
                        mst_q <= vb_pkg::M_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cpu responses: data for loads, error for a pio access ending in bus error or timeout
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rsp_v_q <= 1'b0;
            rsp_err_q <= 1'b0;
            rsp_data_q <= 64'h0;
        end else begin
            rsp_v_q <= 1'b0;
            rsp_err_q <= 1'b0;
            if (pio_q && beat_ok && !wr_q) begin
                rsp_v_q <= 1'b1;
                rsp_data_q <= i_vme_rdata;
            end else if (pio_q && beat_err) begin
                rsp_v_q <= 1'b1;
                rsp_err_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dma engine
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            dma_busy_q <= 1'b0;
            dma_done_q <= 1'b0;
            dma_err_q <= 1'b0;
            dma_rd_q <= 1'b0;
            dma_d64_q <= 1'b0;
            half_q <= 1'b0;
            wbuf_v_q <= 1'b0;
            wbuf_q <= 64'h0;
            gath_q <= 32'h0;
            haddr_q <= 40'h0;
            dvaddr_q <= 32'h0;
            beats_q <= 17'h0;
            fetch_q <= 16'h0;
        end else if (i_dma_start && !dma_busy_q) begin
            dma_busy_q <= (i_dma_len != 16'h0);
            dma_done_q <= (i_dma_len == 16'h0);
            dma_err_q <= 1'b0;
            dma_rd_q <= i_dma_rd;
            dma_d64_q <= i_dma_d64;
            haddr_q <= i_dma_haddr;
            dvaddr_q <= i_dma_vaddr;
            beats_q <= i_dma_d64 ? {1'b0, i_dma_len} : {i_dma_len, 1'b0};
            fetch_q <= i_dma_rd ? 16'h0 : i_dma_len;
            half_q <= 1'b0;
            wbuf_v_q <= 1'b0;
        end else begin
            if (!pio_q && beat_ok) begin
                dvaddr_q <= dvaddr_q +
                    (dma_d64_q ? `VB_D64_STEP : `VB_D32_STEP);
                beats_q <= beats_q - 17'h1;
                half_q <= !dma_d64_q && !half_q;
                if (!half_q) begin
                    gath_q <= i_vme_rdata[31:0];
                end
                if (dma_d64_q || half_q) begin
                    wbuf_v_q <= 1'b0;
                end
            end
            if (!pio_q && beat_err) begin
                dma_err_q <= 1'b1;
                dma_busy_q <= 1'b0;
                dma_done_q <= 1'b1;
            end else if (dma_fin) begin
                dma_busy_q <= 1'b0;
                dma_done_q <= 1'b1;
            end
            if (own_q == vb_pkg::OWN_FETCH && i_mem_ack) begin
                wbuf_q <= i_mem_rdata;
                wbuf_v_q <= 1'b1;
                fetch_q <= fetch_q - 16'h1;
                haddr_q <= haddr_q + `VB_MEM_STEP;
            end
            if (fifo_pop) begin
                haddr_q <= haddr_q + `VB_MEM_STEP;
            end
        end
    end

    vb_fifo #(
        .W(`VB_FIFO_W),
        .D(`VB_FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_valid(fifo_push),
        .i_data(fifo_in_d),
        .o_ready(fifo_in_rdy),
        .o_valid(fifo_out_v),
        .o_data(fifo_out_d),
        .i_ready(fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////
    // memory port: slave first so external masters see short latency
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            own_q <= vb_pkg::OWN_NONE;
            mem_we_q <= 1'b0;
            mem_addr_q <= 40'h0;
            mem_wdata_q <= 64'h0;
        end else begin
            unique case (own_q)
                vb_pkg::OWN_NONE: begin
                    if (slv_q == vb_pkg::SL_WAIT) begin
                        own_q <= vb_pkg::OWN_SLV;
                        mem_we_q <= i_vs_write;
                        mem_addr_q <= {i_slv_hbase,
                            i_vs_addr[`VB_SLV_LSB-1:0]};
                        mem_wdata_q <= i_vs_wdata;
                    end else if (fifo_out_v) begin
                        own_q <= vb_pkg::OWN_FIFO;
                        mem_we_q <= 1'b1;
                        mem_addr_q <= haddr_q;
                        mem_wdata_q <= fifo_out_d;
                    end else if (dma_busy_q && !dma_rd_q && !dma_err_q &&
                        !wbuf_v_q && fetch_q != 16'h0) begin
                        own_q <= vb_pkg::OWN_FETCH;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= haddr_q;
                    end
                end
                vb_pkg::OWN_SLV, vb_pkg::OWN_FIFO, vb_pkg::OWN_FETCH: begin
                    if (i_mem_ack) begin
                        own_q <= vb_pkg::OWN_NONE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vme slave into host memory
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            slv_q <= vb_pkg::SL_IDLE;
            vs_rdata_q <= 64'h0;
        end else begin
            unique case (slv_q)
                vb_pkg::SL_IDLE: begin
                    if (slv_hit) begin
                        slv_q <= vb_pkg::SL_WAIT;
                    end
                end
                vb_pkg::SL_WAIT: begin
                    if (own_q == vb_pkg::OWN_SLV && i_mem_ack) begin
                        slv_q <= vb_pkg::SL_ACK;
                        vs_rdata_q <= i_mem_rdata;
                    end
                end
                vb_pkg::SL_ACK: begin
                    if (!i_vs_ds) begin
                        slv_q <= vb_pkg::SL_IDLE;
                    end
                end
                default: slv_q <= vb_pkg::SL_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_sb_ready = (mst_q == vb_pkg::M_IDLE);
    assign o_sb_rsp_valid = rsp_v_q;
    assign o_sb_rsp_err = rsp_err_q;
    assign o_sb_rsp_data = rsp_data_q;
    assign o_mem_req = (own_q != vb_pkg::OWN_NONE);
    assign o_mem_we = mem_we_q;
    assign o_mem_addr = mem_addr_q;
    assign o_mem_wdata = mem_wdata_q;
    assign o_vme_br = (mst_q != vb_pkg::M_IDLE);
    assign o_vme_as = (mst_q == vb_pkg::M_STROBE) ||
        (mst_q == vb_pkg::M_RELEASE);
    assign o_vme_ds = (mst_q == vb_pkg::M_STROBE);
    assign o_vme_write = wr_q;
    assign o_vme_am = am_code(i_am_super, !pio_q, !pio_q && dma_d64_q);
    assign o_vme_d64 = !pio_q && dma_d64_q;
    assign o_vme_addr = vaddr_q;
    assign o_vme_wdata = vwdata_q;
    assign o_vs_dtack = (slv_q == vb_pkg::SL_ACK);
    assign o_vs_rdata = vs_rdata_q;
    assign o_dma_busy = dma_busy_q;
    assign o_dma_done = dma_done_q;
    assign o_dma_err = dma_err_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    AST_XLATE: assert property (
        pio_take |=> mst_q == vb_pkg::M_BUSREQ &&
            o_vme_addr[22:0] == $past(i_sb_addr[22:0])
    ) else $error("pio address not translated");
    AST_RDWAIT: assert property (
        (pio_take && !i_sb_we) |=> (!o_sb_rsp_valid)[*2]
    ) else $error("load answered before vme read");
    AST_RDRET: assert property (
        (beat_ok && pio_q && !wr_q) |=> o_sb_rsp_valid && !o_sb_rsp_err &&
            o_sb_rsp_data == $past(i_vme_rdata)
    ) else $error("load data not returned");
    AST_WRQUIET: assert property (
        (beat_ok && pio_q && wr_q) |=> !o_sb_rsp_valid
    ) else $error("store returned a response");
    AST_DTACK: assert property (
        $fell(o_vme_ds) |-> $past(beat_ok) || $past(beat_err)
    ) else $error("strobe dropped without acknowledge");
    AST_BERR: assert property (
        (beat_err && pio_q) |=> o_sb_rsp_valid && o_sb_rsp_err
    ) else $error("dead pio access not reported");
    AST_SLVHIT: assert property (
        (slv_q == vb_pkg::SL_IDLE && slv_hit) |=> slv_q == vb_pkg::SL_WAIT
    ) else $error("slave hit ignored");
    AST_SLVACK: assert property (
        (slv_q == vb_pkg::SL_WAIT && own_q == vb_pkg::OWN_SLV && i_mem_ack)
            |=> o_vs_dtack && o_vs_rdata == $past(i_mem_rdata)
    ) else $error("slave not acknowledged after memory");
    AST_AM: assert property (
        o_vme_as |-> o_vme_am inside {`VB_AM_SD_SGL, `VB_AM_UD_SGL,
            `VB_AM_SD_BLT, `VB_AM_UD_BLT, `VB_AM_SD_D64, `VB_AM_UD_D64}
    ) else $error("code-space modifier issued");
    AST_PACK: assert property (
        (beat_ok && !pio_q && dma_rd_q && !dma_d64_q && !half_q)
            |-> !fifo_push ##1
            (half_q && gath_q == $past(i_vme_rdata[31:0]))
    ) else $error("half word pushed ungathered");
    AST_START: assert property (
        (i_dma_start && !dma_busy_q && i_dma_len != 16'h0) |=>
            o_dma_busy && !o_dma_done && dvaddr_q == $past(i_dma_vaddr)
    ) else $error("dma setup not taken");
    AST_DMAERR: assert property (
        (beat_err && !pio_q) |=> !o_dma_busy && o_dma_err && o_dma_done
    ) else $error("dma error not shown");

    CV_PIO_READ: cover property (beat_ok && pio_q && !wr_q);
    CV_SLAVE: cover property (o_vs_dtack && i_vs_write);
    CV_DMA_DONE: cover property ($rose(o_dma_done) && !o_dma_err);
    CV_FIFO_FULL: cover property (dma_busy_q && !fifo_in_rdy);
endmodule

/* File: testbench/vb_vme_slave.sv */
// vme slave board model answering the bridge when it is master
`timescale 1ns/100ps
module vb_vme_slave (
    // clock and behaviour
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_slow,
    input wire logic i_absent,
    // cycle from the master
    input wire logic i_ds,
    input wire logic i_write,
    input wire logic [5:0] i_am,
    input wire logic [31:0] i_addr,
    input wire logic [63:0] i_wdata,
    // answer and record of the last beat
    output logic o_dtack,
    output logic [63:0] o_rdata,
    output logic [5:0] o_am,
    output logic [31:0] o_addr,
    output logic [63:0] o_wdata
);
    logic [1:0] wait_q;
    logic hit;
    ////////////////////////////////////////////////////////////
    assign hit = i_rstn && i_ds && !i_absent && !o_dtack &&
        (wait_q == (i_slow ? 2'h3 : 2'h0));
    // acknowledge only a raised strobe, and hold it until strobe drops
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !i_ds || i_absent) begin
            o_dtack <= 1'b0;
            wait_q <= 2'h0;
        end else if (hit) begin
            o_dtack <= 1'b1;
        end else if (!o_dtack) begin
            wait_q <= wait_q + 2'h1;
        end
    end
    // released data lines keep changing so stale values never match
    always_ff @(posedge i_clk) begin
        if (hit) begin
            o_rdata <= {~i_addr, i_addr};
            o_am <= i_am;
            o_addr <= i_addr;
            if (i_write) o_wdata <= i_wdata;
        end else if (!o_dtack) begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

/* File: testbench/tb_vb_bridge.sv */
// self-checking bench of the vme bridge
`timescale 1ns/100ps
module tb_vb_bridge;
    logic i_clk, i_rstn, i_sb_req, i_sb_we, i_win_we, i_am_super, i_mem_ack;
    logic i_vme_bg, i_vme_berr, i_vme_dtack, i_vs_as, i_vs_ds, i_vs_write;
    logic i_dma_start, i_dma_rd, i_dma_d64, slow, absent, o_sb_ready;
    logic o_sb_rsp_valid, o_sb_rsp_err, o_mem_req, o_mem_we, o_vme_br;
    logic o_vme_as, o_vme_ds, o_vme_write, o_vme_d64, o_vs_dtack;
    logic o_dma_busy, o_dma_done, o_dma_err;
    logic [3:0] i_win_idx;
    logic [8:0] i_win_base;
    logic [7:0] i_slv_vbase;
    logic [15:0] i_slv_hbase, i_dma_len;
    logic [5:0] o_vme_am, m_am;
    logic [31:0] o_vme_addr, i_vs_addr, i_dma_vaddr, m_addr;
    logic [39:0] i_sb_addr, o_mem_addr, i_dma_haddr, mw_addr;
    logic [63:0] i_sb_wdata, o_sb_rsp_data, o_mem_wdata, i_mem_rdata;
    logic [63:0] o_vme_wdata, i_vme_rdata, i_vs_wdata, o_vs_rdata;
    logic [63:0] mw_data, m_wdata;
    int errors, compares;
    ////////////////////////////////////////////////////////////
    vb_bridge vb_bridge_i (
        .i_clk, .i_rstn, .i_sb_req, .i_sb_we, .i_sb_addr, .i_sb_wdata,
        .o_sb_ready, .o_sb_rsp_valid, .o_sb_rsp_err, .o_sb_rsp_data,
        .i_win_we, .i_win_idx, .i_win_base, .i_am_super, .o_mem_req,
        .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata,
        .o_vme_br, .i_vme_bg, .o_vme_as, .o_vme_ds, .o_vme_write,
        .o_vme_am, .o_vme_d64, .o_vme_addr, .o_vme_wdata, .i_vme_dtack,
        .i_vme_berr, .i_vme_rdata, .i_vs_as, .i_vs_ds, .i_vs_write,
        .i_vs_addr, .i_vs_wdata, .i_slv_vbase, .i_slv_hbase, .o_vs_dtack,
        .o_vs_rdata, .i_dma_start, .i_dma_rd, .i_dma_d64, .i_dma_haddr,
        .i_dma_vaddr, .i_dma_len, .o_dma_busy, .o_dma_done, .o_dma_err
    );
    vb_vme_slave vb_vme_slave_i (
        .i_clk, .i_rstn, .i_slow(slow), .i_absent(absent), .i_ds(o_vme_ds),
        .i_write(o_vme_write), .i_am(o_vme_am), .i_addr(o_vme_addr),
        .i_wdata(o_vme_wdata), .o_dtack(i_vme_dtack), .o_rdata(i_vme_rdata),
        .o_am(m_am), .o_addr(m_addr), .o_wdata(m_wdata)
    );
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // arbiter grants at once; memory answers in the same cycle as a request
    always @(negedge i_clk) begin
        i_vme_bg <= o_vme_br;
        i_mem_ack <= o_mem_req && !i_mem_ack;
        i_mem_rdata <= {o_mem_addr[31:0], ~o_mem_addr[31:0]};
    end
    always @(posedge i_clk) begin
        if (o_mem_req && i_mem_ack && o_mem_we) begin
            mw_addr <= o_mem_addr;
            mw_data <= o_mem_wdata;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic complete_run();
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic set_win(input logic [3:0] idx, input logic [8:0] base);
        {i_win_we, i_win_idx, i_win_base} = {1'b1, idx, base};
        tick(1);
        i_win_we = 1'b0;
        tick(1);
    endtask
    // one cpu access, answer watched until the master is idle again
    task automatic cpu(input logic w, input logic [39:0] a,
            input logic [63:0] d, output logic got, output logic err,
            output logic [63:0] q);
        {i_sb_req, i_sb_we, i_sb_addr, i_sb_wdata} = {1'b1, w, a, d};
        {got, err, q} = '0;
        tick(1);
        i_sb_req = 1'b0;
        tick(1);
        for (int n = 0; n < 200 && o_sb_ready !== 1'b1; n++) begin
            tick(1);
            if (o_sb_rsp_valid === 1'b1) {got, err, q} = {2'b11,
                o_sb_rsp_err, o_sb_rsp_data};
        end
    endtask
    task automatic pio();
        logic g, e;
        logic [63:0] q;
        set_win(4'h1, 9'h0a5);
        set_win(4'hb, 9'h1ff);
        cpu(1'b0, {13'h0002, 4'h1, 23'h012340}, 64'h0, g, e, q);
        check({g, e}, 2'b10);
        check(q[31:0], {9'h0a5, 23'h012340});
        check(m_addr, {9'h0a5, 23'h012340});
        check(m_am, 6'h0d);
        {slow, i_am_super} = 2'b10;
        cpu(1'b1, {13'h0002, 4'hb, 23'h000010}, 64'h11223344_55667788, g, e, q);
        check(g, 1'b0);
        check({m_addr, m_wdata[31:0]}, {9'h1ff, 23'h10, 32'h55667788});
        check(m_am, 6'h09);
        cpu(1'b0, {13'h0002, 4'hc, 23'h0}, 64'h0, g, e, q);
        check(g, 1'b0);
        {slow, absent, i_am_super} = 3'b011;
        cpu(1'b0, {13'h0002, 4'h1, 23'h0}, 64'h0, g, e, q);
        check({g, e}, 2'b11);
        absent = 1'b0;
    endtask
    // external master cycle; strobes dropped between cycles
    task automatic vs(input logic w, input logic [31:0] a,
            output logic got, output logic [63:0] q);
        {i_vs_as, i_vs_ds, i_vs_write, i_vs_addr, got} = {3'b111 & {2'b11, w},
            a, 1'b0};
        for (int n = 0; n < 50 && !got; n++) begin
            tick(1);
            if (o_vs_dtack === 1'b1) {got, q} = {1'b1, o_vs_rdata};
        end
        {i_vs_as, i_vs_ds, i_vs_wdata} = {2'b00, ~i_vs_wdata};
        for (int n = 0; n < 10 && o_vs_dtack !== 1'b0; n++) tick(1);
    endtask
    task automatic slave();
        logic g;
        logic [63:0] q;
        i_vs_wdata = 64'hcafe0123_4567beef;
        vs(1'b1, 32'h4000_1238, g, q);
        check(g, 1'b1);
        check(mw_addr, 40'h00_1200_1238);
        check(mw_data, 64'hcafe0123_4567beef);
        vs(1'b0, 32'h4000_0100, g, q);
        check(q, {32'h1200_0100, ~32'h1200_0100});
        vs(1'b0, 32'h4100_0000, g, q);
        check(g, 1'b0);
    endtask
    // an absent slave must end the transfer in error, not hang it
    task automatic dma(input logic rd, input logic d64, input logic ab);
        logic [31:0] va = 32'h2000_0000;
        logic [39:0] ha = 40'h00_0000_1000;
        logic [63:0] mp = {ha[31:0], ~ha[31:0]};
        {i_dma_rd, i_dma_d64, i_dma_haddr, i_dma_vaddr} = {rd, d64, ha, va};
        {i_dma_len, i_dma_start, slow, absent} = {16'h1, 1'b1, d64, ab};
        i_am_super = !rd;
        tick(1);
        i_dma_start = 1'b0;
        check(o_dma_busy, 1'b1);
        for (int n = 0; n < 400 && o_dma_done !== 1'b1; n++) tick(1);
        check({o_dma_done, o_dma_err, o_dma_busy}, {1'b1, ab, 1'b0});
        if (ab) return;
        check(o_vme_d64, d64);
        check(m_am, d64 ? (rd ? 6'h08 : 6'h0c) :
            (rd ? 6'h0b : 6'h0f));
        if (rd) check(mw_data, d64 ? {~va, va} : {va + 32'h4, va});
        if (rd) check(mw_addr, ha);
        if (!rd) check(d64 ? m_wdata : {32'h0, m_wdata[31:0]},
            d64 ? mp : {32'h0, mp[63:32]});
        if (!rd) check(m_addr, d64 ? va : va + 32'h4);
    endtask
    initial begin
        {errors, compares} = '0;
        {i_rstn, i_sb_req, i_sb_we, i_sb_addr, i_sb_wdata, i_win_we} = '0;
        {i_win_idx, i_win_base, i_mem_ack, i_mem_rdata, i_vme_bg} = '0;
        {i_vme_berr, i_vs_as, i_vs_ds, i_vs_write, i_vs_addr} = '0;
        {i_vs_wdata, i_dma_start, i_dma_rd, i_dma_d64, i_dma_haddr} = '0;
        {i_dma_vaddr, i_dma_len, slow, absent} = '0;
        {i_am_super, i_slv_vbase, i_slv_hbase} = {1'b1, 8'h40, 16'h0012};
        tick(4);
        i_rstn = 1'b1;
        pio();
        slave();
        for (int k = 0; k < 5; k++) dma(k[1], k[0], k[2]);
        complete_run();
    end
    // whole run needs well under 3000 cycles
    initial begin
        #300000;
        errors++;
        complete_run();
    end
endmodule
